// ===== bench/dus_sched_props.sv
// Port-level checker for the converter update scheduler
`timescale 1ns/10ps

module dus_sched_props
   import dus_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [DUS_DATA_W-1:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic tmr3Ovf,
   input wire logic tmr4Ovf,
   input wire logic tmr2Ovf,
   input wire logic [DUS_CODE_W-1:0] convCode0,
   input wire logic [DUS_CODE_W-1:0] convCode1,
   input wire logic convEnable0,
   input wire logic convEnable1
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   // Cycles since the last write response or overflow pin activity
   logic [3:0] quiet;
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         quiet <= 4'hF;
      end else if (s_axi_bvalid || tmr3Ovf || tmr4Ovf || tmr2Ovf) begin
         quiet <= 4'h0;
      end else if (quiet != 4'hF) begin
         quiet <= quiet + 4'h1;
      end
   end

   reset_state_a: assert property (
      $fell(rst) |-> convCode0 == 12'h000 && convCode1 == 12'h000
         && !convEnable0 && !convEnable1 && !s_axi_bvalid)
      else $error("state not cleared by reset");
   code_quiet_a: assert property (
      $changed(convCode0) || $changed(convCode1) |-> quiet < 4'h9)
      else $error("latch changed without write or overflow");
   write_answer_a: assert property (
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
         |-> ##[1:16] s_axi_bvalid)
      else $error("write response missing");
   aw_refuse_a: assert property (
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write accepted while response pending");
   bresp_hold_a: assert property (
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   read_answer_a: assert property (
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
      else $error("read answer late");
   rvalid_hold_a: assert property (
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped early");
   rdata_upper_a: assert property (
      s_axi_rvalid |-> s_axi_rdata[31:12] == 20'h00000)
      else $error("read data upper bits set");
endmodule

bind dus_scheduler dus_sched_props u_props (.clk_sys(clk_sys), .rst(rst),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .tmr3Ovf(tmr3Ovf), .tmr4Ovf(tmr4Ovf), .tmr2Ovf(tmr2Ovf),
   .convCode0(convCode0), .convCode1(convCode1),
   .convEnable0(convEnable0), .convEnable1(convEnable1));

// ===== bench/dus_tmr_model.sv
// Overflow pin source standing in for the on-chip timers
`timescale 1ns/10ps

module dus_tmr_model #(
   parameter int HOLD = 3
) (
   input wire logic clk_sys,
   input wire logic [2:0] fire,
   output logic tmr3Ovf,
   output logic tmr4Ovf,
   output logic tmr2Ovf
);
   int cnt [3] = '{0, 0, 0};
   logic [2:0] lvl = 3'h0;

   // One high phase of HOLD cycles, then a low gap of at least HOLD + 1 cycles so events never merge
   always @(posedge clk_sys) begin
      for (int i = 0; i < 3; i++) begin
         if (fire[i] && cnt[i] == 0) begin
            cnt[i] <= 2 * HOLD;
            lvl[i] <= 1'b1;
         end else if (cnt[i] != 0) begin
            cnt[i] <= cnt[i] - 1;
            lvl[i] <= (cnt[i] > HOLD + 1);
         end
      end
   end

   // Index order follows the mode code
   assign tmr3Ovf = lvl[0];
   assign tmr4Ovf = lvl[1];
   assign tmr2Ovf = lvl[2];
endmodule

// ===== bench/tb_dac_update_scheduler.sv
// Self-checking bench for the converter update scheduler
`timescale 1ns/10ps

module tb_dac_update_scheduler
   import dus_pkg::*;
;
   typedef struct packed {
      logic [7:0] base, ctrl, lo, hi;
      logic [11:0] code;
   } dus_row_type;

   logic clk_sys, rst;
   logic [DUS_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
   logic [DUS_DATA_W-1:0] s_axi_wdata, s_axi_rdata, rd;
   logic [DUS_STRB_W-1:0] s_axi_wstrb;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready, tmr3Ovf, tmr4Ovf, tmr2Ovf;
   logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
   logic [DUS_CODE_W-1:0] convCode0, convCode1, cur;
   logic convEnable0, convEnable1;
   logic [2:0] fire;
   int n_mismatch, checks, lag;
   dus_row_type rows [6] = '{
      '{8'h00, 8'h80, 8'hFF, 8'h0F, 12'hFFF},
      '{8'h10, 8'h81, 8'hAA, 8'h15, 12'hAD5},
      '{8'h00, 8'h82, 8'hC0, 8'h3F, 12'hFF0},
      '{8'h10, 8'h83, 8'h08, 8'h01, 12'h021},
      '{8'h00, 8'h84, 8'h00, 8'h80, 12'h800},
      '{8'h10, 8'h87, 8'h00, 8'h00, 12'h000}};

   dus_scheduler uut (.clk_sys(clk_sys), .rst(rst),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .tmr3Ovf(tmr3Ovf), .tmr4Ovf(tmr4Ovf),
      .tmr2Ovf(tmr2Ovf), .convCode0(convCode0), .convCode1(convCode1),
      .convEnable0(convEnable0), .convEnable1(convEnable1));
   dus_tmr_model tmr (.clk_sys(clk_sys), .fire(fire), .tmr3Ovf(tmr3Ovf),
      .tmr4Ovf(tmr4Ovf), .tmr2Ovf(tmr2Ovf));

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic finish_test;
      $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
   endtask

   // Handshakes are sampled mid-cycle, acted on at the next rising edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic ta, tw, tb;
      @(posedge clk_sys);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h000000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      for (int i = 0; i < 64; i++) begin
         @(negedge clk_sys);
         ta = s_axi_awvalid && s_axi_awready;
         tw = s_axi_wvalid && s_axi_wready;
         tb = s_axi_bvalid && s_axi_bready;
         rsp = s_axi_bresp;
         @(posedge clk_sys);
         if (ta) s_axi_awvalid <= 1'b0;
         if (tw) s_axi_wvalid <= 1'b0;
         if (tb) begin
            s_axi_bready <= 1'b0;
            return;
         end
         if (i >= lag) s_axi_bready <= 1'b1;
      end
      n_mismatch++;
      finish_test();
   endtask

   task automatic rdr(input logic [7:0] a);
      logic ta, tr;
      @(posedge clk_sys);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      for (int i = 0; i < 64; i++) begin
         @(negedge clk_sys);
         ta = s_axi_arvalid && s_axi_arready;
         tr = s_axi_rvalid && s_axi_rready;
         rd = s_axi_rdata;
         rsp = s_axi_rresp;
         @(posedge clk_sys);
         if (ta) s_axi_arvalid <= 1'b0;
         if (tr) begin
            s_axi_rready <= 1'b0;
            return;
         end
         if (i >= lag) s_axi_rready <= 1'b1;
      end
      n_mismatch++;
      finish_test();
   endtask

   task automatic pulse(input logic [2:0] f);
      @(posedge clk_sys);
      fire <= f;
      @(posedge clk_sys);
      fire <= 3'h0;
      tick(12);
   endtask

   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end

   // Hang guard
   initial begin
      repeat (50000) @(posedge clk_sys);
      n_mismatch++;
      finish_test();
   end

   initial begin
      rst = 1'b1;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 4'h0;
      {s_axi_rready, fire, lag} = 0;
      s_axi_awaddr = 8'h00;
      s_axi_araddr = 8'h00;
      s_axi_wdata = 32'h00000000;
      s_axi_wstrb = 4'hF;
      tick(10);
      rst <= 1'b0;
      chk({convEnable1, convEnable0, convCode1, convCode0}, 0);
      rdr(8'h00);
      chk(rd, 32'h00000000);
      // Plain on-demand loads in every justification
      foreach (rows[k]) begin
         wr(rows[k].base, rows[k].ctrl);
         wr(rows[k].base + 8'h04, rows[k].lo);
         wr(rows[k].base + 8'h08, rows[k].hi);
         tick(2);
         cur = rows[k].base[4] ? convCode1 : convCode0;
         chk(cur, rows[k].code);
         rdr(rows[k].base + 8'h0C);
         chk(rd, {20'h00000, rows[k].code});
         chk(rows[k].base[4] ? convEnable1 : convEnable0, 1'b1);
      end
      $display("row table done");
      // Low byte alone is held; high-only updates reuse it
      wr(8'h04, 8'hF0);
      tick(2);
      chk(convCode0, 12'h800);
      wr(8'h08, 8'h12);
      tick(2);
      chk(convCode0, 12'h12F);
      wr(8'h08, 8'h34);
      tick(2);
      chk(convCode0, 12'h34F);
      wr(8'h10, 8'h00);
      chk(convEnable1, 1'b0);
      chk(convEnable0, 1'b1);
      wr(8'h00, 8'hFF);
      rdr(8'h00);
      chk(rd, {24'h000000, DUS_CTRL_WMASK});
      $display("demand tests done");
      cur = 12'h34F;
      // Each timer mode, with the other timers firing first
      for (int m = 1; m < 4; m++) begin
         wr(8'h00, 8'h80 | 8'(m << 3));
         wr(8'h04, 8'(m << 4));
         wr(8'h08, 8'(m));
         tick(6);
         chk(convCode0, cur);
         pulse(3'h7 & ~3'(1 << (m - 1)));
         chk(convCode0, cur);
         pulse(3'(1 << (m - 1)));
         cur = 12'(m << 8) | 12'(m << 4);
         chk(convCode0, cur);
      end
      // Second converter on its own timer, first converter left alone
      wr(8'h10, 8'h90);
      wr(8'h14, 8'h40);
      wr(8'h18, 8'h05);
      tick(6);
      chk(convCode1, 12'h000);
      pulse(3'h2);
      chk(convCode1, 12'h540);
      chk(convCode0, cur);
      $display("timer tests done");
      // Slow response takers, error and ignored addresses
      lag = 2;
      wr(8'h20, 8'h55);
      chk(rsp, DUS_RESP_SLVERR);
      rdr(8'h21);
      chk(rsp, DUS_RESP_SLVERR);
      rdr(8'h05);
      chk(rsp, DUS_RESP_SLVERR);
      // Write with the data lane strobe off changes nothing
      s_axi_wstrb <= 4'hE;
      wr(8'h08, 8'h77);
      chk(rsp, DUS_RESP_OKAY);
      s_axi_wstrb <= 4'hF;
      rdr(8'h08);
      chk(rd, 32'h00000003);
      wr(8'h0C, 8'hFF);
      chk(rsp, DUS_RESP_OKAY);
      tick(2);
      chk(convCode0, cur);
      lag = 0;
      // Reset in mid-run
      rst <= 1'b1;
      tick(2);
      rst <= 1'b0;
      tick(1);
      chk({convEnable0, convCode0}, 0);
      rdr(8'h00);
      chk(rd, 32'h00000000);
      rdr(8'h08);
      chk(rd, 32'h00000000);
      $display("error and reset tests done");
      finish_test();
   end
endmodule

// ===== core/dus_fifo.sv
// Small shift-register queue whose head sits in a register
`timescale 1ns/10ps

module dus_fifo #(
   parameter int WIDTH = 10,
   parameter int DEPTH = 4
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData
);

   localparam int CNT_W = $clog2(DEPTH + 1);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [CNT_W-1:0] count;
   } dus_fifo_state_type;

   dus_fifo_state_type st;
   dus_fifo_state_type next_st;
   logic push;
   logic pop;
   logic [CNT_W-1:0] wIdx;

   // Honest flags straight from the fill count
   assign inReady = (st.count != CNT_W'(DEPTH));
   assign outValid = (st.count != '0);
   assign outData = st.mem[0];
   assign push = inValid && inReady;
   assign pop = outValid && outReady;

   // Pop shifts toward the head, push lands behind the last entry
   always_comb begin
      next_st = st;
      wIdx = st.count - CNT_W'(pop);
      if (pop) begin
         for (int i = 0; i < DEPTH - 1; i++) begin
            next_st.mem[i] = st.mem[i + 1];
         end
      end
      if (push) begin
         next_st.mem[wIdx] = inData;
      end
      next_st.count = st.count + CNT_W'(push) - CNT_W'(pop);
   end

   // State register
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

endmodule

// ===== core/dus_scheduler.sv
// Update scheduler for two 12-bit converters behind an AXI4-Lite slave
//
// Our own choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/10ps

// Function
// - Each converter takes a 12-bit unsigned code from 0x000 to 0xFFF
// - Each converter has its own enable bit in its control register
// - A disabled converter keeps its output enable low, output high-impedance
// - Mode 00 copies staged data into the latch on a high-byte write
// - In mode 00 a low-byte write is only staged, output unchanged
// - Modes 01, 10, 11 hold both bytes until Timer 3, 4, 2 overflow
// - On selected overflow, high and low bytes go to the latch together
// - Second converter schedules identically with its own registers
// - Control bits 2:0 pick one of five placements of the word
module dus_scheduler
   import dus_pkg::*;
#(
   parameter int FIFO_DEPTH = DUS_FIFO_DEPTH
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [DUS_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [DUS_DATA_W-1:0] s_axi_wdata,
   input wire logic [DUS_STRB_W-1:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [DUS_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [DUS_DATA_W-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic tmr3Ovf,
   input wire logic tmr4Ovf,
   input wire logic tmr2Ovf,
   output logic [DUS_CODE_W-1:0] convCode0,
   output logic [DUS_CODE_W-1:0] convCode1,
   output logic convEnable0,
   output logic convEnable1
);

   // Block state apart from the staging queue, registered in one place
   typedef struct packed {
      logic awHeld;
      logic [DUS_ADDR_W-1:0] awAddr;
      logic wHeld;
      logic [DUS_DATA_W-1:0] wData;
      logic [DUS_STRB_W-1:0] wStrb;
      logic bValid;
      logic [1:0] bResp;
      logic rValid;
      logic [DUS_DATA_W-1:0] rData;
      logic [1:0] rResp;
      logic [DUS_NCONV-1:0][DUS_BYTE_W-1:0] ctrl;
      logic [DUS_NCONV-1:0][DUS_BYTE_W-1:0] low;
      logic [DUS_NCONV-1:0][DUS_BYTE_W-1:0] high;
      logic [DUS_NCONV-1:0][DUS_CODE_W-1:0] latch;
      logic [DUS_NTMR-1:0] tmrMeta;
      logic [DUS_NTMR-1:0] tmrSync;
      logic [DUS_NTMR-1:0] tmrLast;
   } dus_state_type;

   dus_state_type st;
   dus_state_type next_st;

   // Reset image from the named reset values, so a changed reset
   // value needs no edit in the state register; the rest starts clear
   function automatic dus_state_type resetImage();
      dus_state_type r;
      r = '0;
      for (int i = 0; i < DUS_NCONV; i++) begin
         r.ctrl[i] = DUS_CTRL_RST;
         r.low[i] = DUS_DATA_RST;
         r.high[i] = DUS_DATA_RST;
      end
      return r;
   endfunction

   localparam dus_state_type ST_RESET = resetImage();

   logic [DUS_NTMR-1:0] tmrPulse;
   logic [DUS_NCONV-1:0] copyNow;
   logic awReady;
   logic wReady;
   logic arReady;
   logic fifoInValid;
   logic fifoInReady;
   logic [DUS_ENTRY_W-1:0] fifoInData;
   logic fifoOutValid;
   logic fifoOutReady;
   logic [DUS_ENTRY_W-1:0] fifoOutData;

   // Map a byte address onto converter and register select
   function automatic dus_dec_type decode(
      input logic [DUS_ADDR_W-1:0] addr
   );
      dus_dec_type d;
      d.hit = (addr[DUS_ALIGN_W-1:0] == '0) && (addr < DUS_MAP_END);
      d.conv = addr[DUS_CONV_BIT];
      d.sel = addr[DUS_SEL_LSB +: DUS_SEL_W];
      return d;
   endfunction

   // Field accessors for a control byte
   function automatic dus_mode_type modeOf(
      input logic [DUS_BYTE_W-1:0] ctrl
   );
      return dus_mode_type'(ctrl[DUS_MODE_LSB +: DUS_MODE_W]);
   endfunction

   // Timer pulse that schedules a copy in the given mode
   function automatic logic timerPick(
      input dus_mode_type mode,
      input logic [DUS_NTMR-1:0] pulse
   );
      logic hit;
      hit = 1'b0;
      unique case (mode)
         DUS_MODE_DEMAND: hit = 1'b0;
         DUS_MODE_TMR3: hit = pulse[DUS_TMR3_IDX];
         DUS_MODE_TMR4: hit = pulse[DUS_TMR4_IDX];
         DUS_MODE_TMR2: hit = pulse[DUS_TMR2_IDX];
      endcase
      return hit;
   endfunction

   // Extract the 12-bit code from the byte pair per placement
   function automatic logic [DUS_CODE_W-1:0] justify(
      input logic [DUS_BYTE_W-1:0] ctrl,
      input logic [DUS_BYTE_W-1:0] hi,
      input logic [DUS_BYTE_W-1:0] lo
   );
      logic [DUS_FMT_W-1:0] fmt;
      logic [DUS_WORD_W-1:0] word;
      logic [DUS_WORD_W-1:0] shifted;
      // Shift by the format code, then keep the low code bits
      fmt = ctrl[DUS_FMT_LSB +: DUS_FMT_W];
      word = {hi, lo};
      // Top format bit set means left-justified, low bits ignored
      if (fmt[DUS_FMT_W-1]) begin
         shifted = word >> (DUS_WORD_W - DUS_CODE_W);
      end else begin
         shifted = word >> fmt[DUS_FMT_W-2:0];
      end
      return shifted[DUS_CODE_W-1:0];
   endfunction

   // Overflow edges after the two-flop synchroniser
   assign tmrPulse = st.tmrSync & ~st.tmrLast;

   // Which converters copy staged data this cycle
   always_comb begin
      for (int i = 0; i < DUS_NCONV; i++) begin
         copyNow[i] = timerPick(modeOf(st.ctrl[i]), tmrPulse);
      end
   end

   // Queue drain waits while a timer copy is in flight, so a byte
   // never lands in the same cycle its pair is being latched
   assign fifoOutReady = ~|copyNow;

   // One write and one read in flight; held halves block new ones
   // Answer comes one edge after both halves are held, later on a stall
   assign awReady = !st.awHeld && !st.bValid;
   assign wReady = !st.wHeld && !st.bValid;
   assign arReady = !st.rValid;

   // Staging queue for data-byte writes
   dus_fifo #(
      .WIDTH(DUS_ENTRY_W),
      .DEPTH(FIFO_DEPTH)
   ) u_stage_fifo (
      .clk_sys(clk_sys),
      .rst(rst),
      .inValid(fifoInValid),
      .inReady(fifoInReady),
      .inData(fifoInData),
      .outValid(fifoOutValid),
      .outReady(fifoOutReady),
      .outData(fifoOutData)
   );

   // Next-state logic for bus, staging and latches
   always_comb begin
      dus_dec_type wDec;
      dus_dec_type rDec;
      logic isData;
      logic isCtrl;
      logic lane;
      logic done;
      logic qConv;
      logic qHigh;
      logic [DUS_BYTE_W-1:0] qByte;
      logic [DUS_BYTE_W-1:0] wByte;

      next_st = st;
      fifoInValid = 1'b0;
      fifoInData = '0;
      wDec = decode(st.awAddr);
      rDec = decode(s_axi_araddr);
      isData = 1'b0;
      isCtrl = 1'b0;
      lane = 1'b0;
      done = 1'b0;
      wByte = st.wData[DUS_BYTE_W-1:0];
      qConv = fifoOutData[DUS_ENTRY_W-1];
      qHigh = fifoOutData[DUS_ENTRY_W-2];
      qByte = fifoOutData[DUS_BYTE_W-1:0];

      // Overflow inputs come from another clock, two flops first
      next_st.tmrMeta = {tmr2Ovf, tmr4Ovf, tmr3Ovf};
      next_st.tmrSync = st.tmrMeta;
      next_st.tmrLast = st.tmrSync;

      // Address and data channels are taken in either order
      if (s_axi_awvalid && awReady) begin
         next_st.awHeld = 1'b1;
         next_st.awAddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && wReady) begin
         next_st.wHeld = 1'b1;
         next_st.wData = s_axi_wdata;
         next_st.wStrb = s_axi_wstrb;
      end

      // Response retires on bready
      if (st.bValid && s_axi_bready) begin
         next_st.bValid = 1'b0;
      end

      // Finish a write once both halves are held
      if (st.awHeld && st.wHeld) begin
         isData = wDec.hit &&
            (wDec.sel == DUS_SEL_LOW || wDec.sel == DUS_SEL_HIGH);
         isCtrl = wDec.hit && (wDec.sel == DUS_SEL_CTRL);
         lane = st.wStrb[DUS_LANE_BIT];
         if (isData && lane) begin
            // Full queue stalls the response, which stalls the master
            fifoInValid = 1'b1;
            fifoInData = {wDec.conv, wDec.sel == DUS_SEL_HIGH, wByte};
            done = fifoInReady;
         end else if (isCtrl && lane) begin
            // Mode change waits for queued bytes so they keep the
            // mode they were written under
            done = !fifoOutValid;
            if (done) begin
               next_st.ctrl[wDec.conv] = wByte & DUS_CTRL_WMASK;
            end
         end else begin
            // Latch readback and empty strobes write nothing
            done = 1'b1;
         end
         if (done) begin
            next_st.awHeld = 1'b0;
            next_st.wHeld = 1'b0;
            next_st.bValid = 1'b1;
            next_st.bResp = wDec.hit ? DUS_RESP_OKAY : DUS_RESP_SLVERR;
         end
      end

      // Apply one queued byte to its converter's staging pair
      if (fifoOutValid && fifoOutReady) begin
         if (qHigh) begin
            next_st.high[qConv] = qByte;
            // On-demand mode copies on the high-byte write
            if (modeOf(st.ctrl[qConv]) == DUS_MODE_DEMAND) begin
               next_st.latch[qConv] =
                  justify(st.ctrl[qConv], qByte, st.low[qConv]);
            end
         end else begin
            next_st.low[qConv] = qByte;
         end
      end

      // Timer-scheduled copy, both bytes in one step, per converter
      // Queue drain is held off now, so the pair cannot tear
      for (int i = 0; i < DUS_NCONV; i++) begin
         if (copyNow[i]) begin
            next_st.latch[i] =
               justify(st.ctrl[i], st.high[i], st.low[i]);
         end
      end

      // Read channel, one access at a time
      // Unmapped reads answer zero with an error response
      if (st.rValid && s_axi_rready) begin
         next_st.rValid = 1'b0;
      end
      if (s_axi_arvalid && arReady) begin
         next_st.rValid = 1'b1;
         next_st.rResp = rDec.hit ? DUS_RESP_OKAY : DUS_RESP_SLVERR;
         next_st.rData = '0;
         if (rDec.hit) begin
            unique case (rDec.sel)
               DUS_SEL_CTRL:
                  next_st.rData = DUS_DATA_W'(st.ctrl[rDec.conv]);
               DUS_SEL_LOW:
                  next_st.rData = DUS_DATA_W'(st.low[rDec.conv]);
               DUS_SEL_HIGH:
                  next_st.rData = DUS_DATA_W'(st.high[rDec.conv]);
               DUS_SEL_LATCH:
                  next_st.rData = DUS_DATA_W'(st.latch[rDec.conv]);
            endcase
         end
      end
   end

   // State register; all-zero reset is on-demand, off, zero data
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         st <= ST_RESET;
      end else begin
         st <= next_st;
      end
   end

   // Bus outputs
   // Response and read data come straight from registers
   assign s_axi_awready = awReady;
   assign s_axi_wready = wReady;
   assign s_axi_bvalid = st.bValid;
   assign s_axi_bresp = st.bResp;
   assign s_axi_arready = arReady;
   assign s_axi_rvalid = st.rValid;
   assign s_axi_rdata = st.rData;
   assign s_axi_rresp = st.rResp;

   // Codes change only at a copy, never while bytes trickle in
   // Converter outputs; low enable keeps the output high-impedance
   assign convCode0 = st.latch[0];
   assign convCode1 = st.latch[1];
   assign convEnable0 = st.ctrl[0][DUS_CTRL_EN_BIT];
   assign convEnable1 = st.ctrl[1][DUS_CTRL_EN_BIT];

endmodule

// ===== inc/dus_pkg.sv
// Shared constants and types for the converter update scheduler
package dus_pkg;

   // Bus geometry
   localparam int DUS_ADDR_W = 8;
   localparam int DUS_DATA_W = 32;
   localparam int DUS_STRB_W = 4;
   localparam int DUS_LANE_BIT = 0;

   // Converter geometry
   localparam int DUS_NCONV = 2;
   localparam int DUS_BYTE_W = 8;
   localparam int DUS_CODE_W = 12;
   localparam int DUS_WORD_W = 16;

   // Register map, byte addresses of the first converter
   localparam logic [DUS_ADDR_W-1:0] DUS_CTRL0_ADDR = 8'h00;
   localparam logic [DUS_ADDR_W-1:0] DUS_LOW0_ADDR = 8'h04;
   localparam logic [DUS_ADDR_W-1:0] DUS_HIGH0_ADDR = 8'h08;
   localparam logic [DUS_ADDR_W-1:0] DUS_LATCH0_ADDR = 8'h0C;
   // Second converter repeats the group at this stride
   localparam logic [DUS_ADDR_W-1:0] DUS_CONV_STRIDE = 8'h10;
   localparam logic [DUS_ADDR_W-1:0] DUS_MAP_END = 8'h20;

   // Address decode fields
   localparam int DUS_ALIGN_W = 2;
   localparam int DUS_SEL_LSB = 2;
   localparam int DUS_SEL_W = 2;
   localparam int DUS_CONV_BIT = 4;
   localparam logic [DUS_SEL_W-1:0] DUS_SEL_CTRL = 2'h0;
   localparam logic [DUS_SEL_W-1:0] DUS_SEL_LOW = 2'h1;
   localparam logic [DUS_SEL_W-1:0] DUS_SEL_HIGH = 2'h2;
   localparam logic [DUS_SEL_W-1:0] DUS_SEL_LATCH = 2'h3;

   // Control register fields
   localparam int DUS_CTRL_EN_BIT = 7;
   localparam int DUS_MODE_LSB = 3;
   localparam int DUS_MODE_W = 2;
   localparam int DUS_FMT_LSB = 0;
   localparam int DUS_FMT_W = 3;
   localparam logic [DUS_BYTE_W-1:0] DUS_CTRL_WMASK = 8'h9F;
   localparam logic [DUS_BYTE_W-1:0] DUS_CTRL_RST = 8'h00;
   localparam logic [DUS_BYTE_W-1:0] DUS_DATA_RST = 8'h00;

   // Timer overflow inputs, index order follows the mode code
   localparam int DUS_NTMR = 3;
   localparam int DUS_TMR3_IDX = 0;
   localparam int DUS_TMR4_IDX = 1;
   localparam int DUS_TMR2_IDX = 2;

   // Staging queue
   localparam int DUS_FIFO_DEPTH = 4;
   localparam int DUS_ENTRY_W = 10;

   // AXI responses
   localparam logic [1:0] DUS_RESP_OKAY = 2'h0;
   localparam logic [1:0] DUS_RESP_SLVERR = 2'h2;

   // Update modes in field order
   typedef enum logic [DUS_MODE_W-1:0] {
      DUS_MODE_DEMAND,
      DUS_MODE_TMR3,
      DUS_MODE_TMR4,
      DUS_MODE_TMR2
   } dus_mode_type;

   // Result of address decode
   typedef struct packed {
      logic hit;
      logic conv;
      logic [DUS_SEL_W-1:0] sel;
   } dus_dec_type;

endpackage
